//--- dv/dcr_mc_model.sv
// memory controller model: link clock, mode writes and readout reads
`timescale 1ns/100ps
module dcr_mc_model #(
    parameter int T_MOD = 12
)
(
    input wire logic clk,
    output logic ck,
    output dcr_pkg::dcr_pin_t pins
);
    import dcr_pkg::*;
    logic locked;

    initial
    begin
        ck = 1'b0;
        pins = DCR_PIN_IDLE;
        #7;
        forever #160 ck = ~ck;
    end

    initial
    begin
        locked = 1'b0;
        repeat (16) @(posedge ck);
        locked = 1'b1;
    end

    // ----------------------------------------
    // command issue
    // ----------------------------------------
    // held from a falling ck over the next rise; on deselect, command lines go high and bank and address lines show inverted values
    task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
        @(negedge ck);
        @(posedge clk);
        pins <= '{cs_n: c[3], ras_n: c[2], cas_n: c[1], we_n: c[0], ba: ba, addr: a};
        @(posedge ck);
        repeat (2) @(posedge clk);
        pins <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: ~ba, addr: ~a};
    endtask

    task automatic mrs(input logic [1:0] r, input logic [13:0] a);
        if (r == DCR_MR_CAL && a[2])
        begin
            cmd(4'h2, 3'h0, 14'h0400);
            repeat (T_MOD) @(posedge ck);
        end
        else if (r == DCR_MR_CAL)
            repeat (T_MOD) @(posedge ck);
        cmd(4'h0, {1'b0, r}, a);
        repeat (T_MOD) @(posedge ck);
    endtask

    // no write task exists, so nothing is written while readout is on
    task automatic rd(input logic [2:0] ba, input logic [13:0] a);
        wait (locked);
        cmd(4'h5, ba, {a[13:2], 2'h0});
    endtask
endmodule

//--- dv/tb_top.sv
// bench: readout bursts, read latency and registers against a reference model
`timescale 1ns/100ps
module tb_top;
    import dcr_pkg::*;
    logic clk, arst_n, ck, avs_read, avs_write, avs_waitrequest, dq_oe, dqs_out, dqs_n_out, dqs_oe;
    logic ck_q = 1'b0, oe_q = 1'b0, dqs_q = 1'b0;
    dcr_pin_t pins;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, ctrl, q;
    logic [31:0] seed = 32'hA84F20CD;
    logic [15:0] dq_out;
    logic [15:0] beats[$];
    logic [13:0] mr[4];
    int miscompares = 0, total_checks = 0, cycles = 0, ck_rises = 0, first_at = 0, m_cnt = 0;

    dcr_readout dcr_readout_inst (.clk(clk), .arst_n(arst_n), .ck(ck), .pins(pins), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe));
    dcr_mc_model #(.T_MOD(12)) dcr_mc_model_inst (.clk(clk), .ck(ck), .pins(pins));

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int rlat();
        int cl;
        cl = mr[0][6:4] + 4;
        return cl + (mr[1][4:3] == 2'h1 ? cl - 1 : mr[1][4:3] == 2'h2 ? cl - 2 : 0) - mr[1][0];
    endfunction

    function automatic logic [31:0] stat();
        return {11'h000, 5'(rlat()), mr[2][5:3], mr[1][4:3], mr[0][6:4], mr[0][1:0], mr[1][0],
            mr[0][6:4] == 3'h2 && mr[2][5:3] == 3'h1, mr[3][1:0], mr[3][2], 1'b0};
    endfunction

    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic mode(input logic [1:0] r, input logic [13:0] a);
        dcr_mc_model_inst.mrs(r, a);
        mr[r] = a;
    endtask

    task automatic cfg(input logic [13:0] b, input logic [13:0] d, input logic [1:0] loc);
        mode(DCR_MR_CAL, 14'h0000);
        mode(DCR_MR_BURST, b);
        mode(DCR_MR_DRIVE, d);
        mode(DCR_MR_CAL, {11'h000, 1'b1, loc});
        av(1'b0, DCR_OFS_STATUS, 32'h0, 4'hF);
        chk("status", stat(), q);
    endtask

    task automatic rd(input logic [13:0] a);
        logic chop;
        int s;
        int s0;
        logic [7:0] p;
        chop = mr[0][1:0] == DCR_BL_FIXED4 || (mr[0][1:0] == DCR_BL_OTF && !a[12]);
        s = chop && a[2] ? 4 : 0;
        p = mr[3][1:0] == 2'h0 ? 8'hAA : ctrl[15:8];
        if (a[2] && !chop)
            return;
        seed = lfsr(seed);
        beats.delete();
        dcr_mc_model_inst.rd(seed[2:0], {1'b0, a[12], seed[11:3], a[2], 2'h0});
        s0 = ck_rises;
        for (int w = 0; w < 300 && !(beats.size() > 0 && dq_oe === 1'b0); w++)
            @(negedge clk);
        chk("beat count", mr[3][2] ? (chop ? 4 : 8) : 0, beats.size());
        if (mr[3][2])
        begin
            m_cnt++;
            chk("latency", rlat(), first_at - s0);
        end
        foreach (beats[i])
            chk("beat", ctrl[0] ? {7'h00, p[s + i], 7'h00, p[s + i]} : {16{p[s + i]}}, beats[i]);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // beats are taken over into the bench clock, one per strobe level
    always @(negedge clk)
    begin
        cycles++;
        ck_q <= ck;
        oe_q <= dq_oe;
        dqs_q <= dqs_out;
        if (ck === 1'b1 && ck_q === 1'b0)
            ck_rises++;
        if (dq_oe === 1'b1 && (oe_q === 1'b0 || dqs_out !== dqs_q))
        begin
            if (oe_q === 1'b0)
                first_at = ck_rises;
            chk("strobe", beats.size() % 2 == 0, dqs_out);
            chk("strobe pair", {1'b1, ~dqs_out}, {dqs_oe, dqs_n_out});
            beats.push_back(dq_out);
        end
        if (cycles == 40000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    initial
    begin
        arst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        mr = '{14'h0020, 14'h0000, 14'h0008, 14'h0000};
        ctrl = 32'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        av(1'b0, DCR_OFS_STATUS, 32'h0, 4'hF);
        chk("reset status", stat(), q);
        rd(14'h1000);
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            ctrl = {16'h0000, seed[15:8], 7'h00, seed[0]};
            av(1'b1, DCR_OFS_CTRL, ctrl, 4'h3);
            cfg({7'h00, 3'h2, 2'h0, 2'(i % 3)}, 14'h0000, 2'(i % 4));
            for (int k = 0; k < 4; k++)
                rd({1'b0, k[1], 9'h000, k[0], 2'h0});
        end
        for (int j = 0; j < 6; j++)
        begin
            mode(DCR_MR_CAL, 14'h0000);
            mode(DCR_MR_WLAT, j == 4 ? 14'h0010 : 14'h0008);
            cfg({7'h00, j < 3 ? 3'h3 : 3'h2, 4'h0}, {9'h000, 2'(j % 3), 2'h0, j == 3 || j == 4}, 2'h0);
            rd(14'h1000);
        end
        av(1'b1, DCR_OFS_CTRL, 32'hFFFFFFFF, 4'h2);
        av(1'b0, DCR_OFS_CTRL, 32'h0, 4'hF);
        chk("control", {16'h0000, 8'hFF, 7'h00, ctrl[0]}, q);
        av(1'b1, DCR_OFS_COUNT, 32'hFFFF, 4'hF);
        av(1'b0, DCR_OFS_COUNT, 32'h0, 4'hF);
        chk("count", m_cnt, q);
        av(1'b0, 4'hC, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
        wrap_up();
    end
endmodule

//--- hdl/dcr_pkg.sv
// package: constants and types of the calibration readout and dll-off read block
package dcr_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] DCR_OFS_CTRL = 4'h0;
    localparam logic [3:0] DCR_OFS_STATUS = 4'h4;
    localparam logic [3:0] DCR_OFS_COUNT = 4'h8;
    localparam int DCR_CTRL_ZERO_BIT = 0;
    localparam int DCR_CTRL_PAT_LSB = 8;

    // ------------------------------------------------------------
    // mode register encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DCR_MR_BURST = 2'h0;
    localparam logic [1:0] DCR_MR_DRIVE = 2'h1;
    localparam logic [1:0] DCR_MR_WLAT = 2'h2;
    localparam logic [1:0] DCR_MR_CAL = 2'h3;
    localparam logic [1:0] DCR_BL_FIXED8 = 2'h0;
    localparam logic [1:0] DCR_BL_OTF = 2'h1;
    localparam logic [1:0] DCR_BL_FIXED4 = 2'h2;
    localparam logic [1:0] DCR_AL_CL1 = 2'h1;
    localparam logic [1:0] DCR_AL_CL2 = 2'h2;
    localparam logic [4:0] DCR_CL_BASE = 5'h04;
    localparam logic [3:0] DCR_CWL_BASE = 4'h5;
    localparam logic [2:0] DCR_CL_RST = 3'h2;
    localparam logic [2:0] DCR_CWL_RST = 3'h1;
    localparam logic [3:0] DCR_DLL_OFF_CL = 4'h6;
    localparam logic [3:0] DCR_DLL_OFF_CWL = 4'h6;

    // ------------------------------------------------------------
    // readout patterns and burst shape
    // ------------------------------------------------------------
    localparam logic [1:0] DCR_LOC_CAL = 2'h0;
    localparam logic [7:0] DCR_PAT_CAL = 8'hAA;
    localparam logic [7:0] DCR_PAT_RSV_RST = 8'h00;
    localparam logic [2:0] DCR_LEFT_BL8 = 3'h7;
    localparam logic [2:0] DCR_LEFT_BC4 = 3'h3;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [13:0] addr;
    } dcr_pin_t;

    localparam dcr_pin_t DCR_PIN_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};

    typedef struct packed {
        logic ck_m;
        logic ck_s;
        logic ck_p;
        dcr_pin_t pin_m;
        dcr_pin_t pin_s;
        dcr_pin_t pin_p;
        logic [1:0] bl_mode;
        logic [2:0] cl_code;
        logic dll_off;
        logic [1:0] al_code;
        logic [2:0] cwl_code;
        logic ro_en;
        logic [1:0] ro_loc;
        logic zero_upper;
        logic [7:0] rsv_pat;
        logic pending;
        logic [4:0] lat;
        logic chop;
        logic [2:0] start_idx;
        logic bursting;
        logic [2:0] beat_idx;
        logic [2:0] left;
        logic [7:0] pat;
        logic [15:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_n;
        logic dqs_oe;
        logic waitreq;
        logic [31:0] rdata;
        logic [15:0] rd_count;
    } dcr_state_t;

    localparam dcr_state_t DCR_STATE_RST = '{pin_m: DCR_PIN_IDLE, pin_s: DCR_PIN_IDLE, pin_p: DCR_PIN_IDLE,
        cl_code: DCR_CL_RST, cwl_code: DCR_CWL_RST, rsv_pat: DCR_PAT_RSV_RST, dqs_n: 1'b1, waitreq: 1'b1,
        default: '0};

endpackage

//--- hdl/dcr_readout.sv
// calibration readout and dll-off read timing of the dram device, with avalon control registers
//
// What this block does
// - both byte lanes bit 0 carry readout bit
// - bits 7..1 replicate bit 0 or zero
// - eight-beat bursts return beats 0 through 7
// - chopped burst returns low or high nibble
// - bank, column 9..3, precharge, bit 11 ignored
// - on-the-fly chop via bit 12 when enabled
// - beat 0 is lsb, beat 7 msb
// - location 00 returns alternating 0,1 pattern
// - readout uses read latency al plus cl
// - drive register bit 0 set turns dll off
// - dll-off supports cas latency 6, write 6
// - dll-off read data one cycle earlier
// - dll-off keeps strobe-to-data relation unchanged
// - auto-precharge read acts as plain read
`timescale 1ns/100ps
module dcr_readout
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ck,
    input wire dcr_pkg::dcr_pin_t pins,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [15:0] dq_out,
    output logic dq_oe,
    output logic dqs_out,
    output logic dqs_n_out,
    output logic dqs_oe
);
    import dcr_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] dcr_rl(input logic [2:0] clc, input logic [1:0] alc, input logic doff);
        logic [4:0] cl;
        logic [4:0] al;
        cl = {2'b00, clc} + DCR_CL_BASE;
        case (alc)
            DCR_AL_CL1: al = cl - 5'h01;
            DCR_AL_CL2: al = cl - 5'h02;
            default: al = 5'h00;
        endcase
        dcr_rl = cl + al - {4'h0, doff};
    endfunction

    function automatic logic [15:0] dcr_lanes(input logic [7:0] pat, input logic [2:0] idx, input logic zero);
        logic b;
        logic [7:0] lane;
        b = pat[idx];
        lane = zero ? {7'h00, b} : {8{b}};
        dcr_lanes = {lane, lane};
    endfunction

    dcr_state_t s;
    dcr_state_t next_s;
    logic rise;
    logic fall;
    logic is_mrs;
    logic is_read;
    logic rd_acc;
    logic [4:0] rl_now;
    logic [3:0] cl_val;
    logic [3:0] cwl_val;
    logic pair_ok;
    logic bc4;

    assign rise = s.ck_s & ~s.ck_p;
    assign fall = ~s.ck_s & s.ck_p;
    assign is_mrs = ~s.pin_p.cs_n & ~s.pin_p.ras_n & ~s.pin_p.cas_n & ~s.pin_p.we_n;
    // read and read-with-precharge decode alike
    assign is_read = ~s.pin_p.cs_n & s.pin_p.ras_n & ~s.pin_p.cas_n & s.pin_p.we_n;
    // one burst in flight; a read during it is dropped
    assign rd_acc = rise & is_read & s.ro_en & ~s.pending & ~s.bursting;
    assign rl_now = dcr_rl(s.cl_code, s.al_code, s.dll_off);
    assign cl_val = {1'b0, s.cl_code} + DCR_CL_BASE[3:0];
    assign cwl_val = {1'b0, s.cwl_code} + DCR_CWL_BASE;
    assign pair_ok = (cl_val == DCR_DLL_OFF_CL) && (cwl_val == DCR_DLL_OFF_CWL);
    assign bc4 = (s.bl_mode == DCR_BL_FIXED4) | ((s.bl_mode == DCR_BL_OTF) & ~s.pin_p.addr[12]);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        // link pins pass two stages; third stage holds pre-edge command
        next_s.ck_m = ck;
        next_s.ck_s = s.ck_m;
        next_s.ck_p = s.ck_s;
        next_s.pin_m = pins;
        next_s.pin_s = s.pin_m;
        next_s.pin_p = s.pin_s;

        if (rise & is_mrs)
        begin
            case (s.pin_p.ba[1:0])
                DCR_MR_BURST:
                begin
                    next_s.bl_mode = s.pin_p.addr[1:0];
                    next_s.cl_code = s.pin_p.addr[6:4];
                end
                DCR_MR_DRIVE:
                begin
                    next_s.dll_off = s.pin_p.addr[0];
                    next_s.al_code = s.pin_p.addr[4:3];
                end
                DCR_MR_WLAT: next_s.cwl_code = s.pin_p.addr[5:3];
                DCR_MR_CAL:
                begin
                    next_s.ro_en = s.pin_p.addr[2];
                    next_s.ro_loc = s.pin_p.addr[1:0];
                end
                default: next_s.ro_en = s.ro_en;
            endcase
        end

        // accept a readout read; only bit 12 and bit 2 matter
        if (rd_acc)
        begin
            next_s.pending = 1'b1;
            next_s.lat = rl_now - 5'h01;
            next_s.chop = bc4;
            next_s.start_idx = bc4 ? {s.pin_p.addr[2], 2'b00} : 3'h0;
            next_s.pat = (s.ro_loc == DCR_LOC_CAL) ? DCR_PAT_CAL : s.rsv_pat;
            next_s.rd_count = s.rd_count + 16'h0001;
        end
        else if (rise & s.pending)
        begin
            if (s.lat == 5'h00)
            begin
                next_s.pending = 1'b0;
                next_s.bursting = 1'b1;
                next_s.beat_idx = s.start_idx;
                next_s.left = s.chop ? DCR_LEFT_BC4 : DCR_LEFT_BL8;
                next_s.dq = dcr_lanes(s.pat, s.start_idx, s.zero_upper);
                next_s.dq_oe = 1'b1;
                next_s.dqs = 1'b1;
                next_s.dqs_n = 1'b0;
                next_s.dqs_oe = 1'b1;
            end
            else
            begin
                next_s.lat = s.lat - 5'h01;
            end
        end

        // one beat per link clock edge; strobe moves with data
        if (s.bursting & (rise | fall))
        begin
            if (s.left == 3'h0)
            begin
                next_s.bursting = 1'b0;
                next_s.dq = 16'h0000;
                next_s.dq_oe = 1'b0;
                next_s.dqs = 1'b0;
                next_s.dqs_n = 1'b1;
                next_s.dqs_oe = 1'b0;
            end
            else
            begin
                next_s.beat_idx = s.beat_idx + 3'h1;
                next_s.left = s.left - 3'h1;
                next_s.dq = dcr_lanes(s.pat, s.beat_idx + 3'h1, s.zero_upper);
                next_s.dqs = ~s.dqs;
                next_s.dqs_n = s.dqs;
            end
        end

        // write lands at the edge where the master sees waitrequest low
        if (avs_write & ~s.waitreq & (avs_address == DCR_OFS_CTRL))
        begin
            if (avs_byteenable[0])
            begin
                next_s.zero_upper = avs_writedata[DCR_CTRL_ZERO_BIT];
            end
            if (avs_byteenable[1])
            begin
                next_s.rsv_pat = avs_writedata[DCR_CTRL_PAT_LSB +: 8];
            end
        end

        // avalon slave: one wait state, then a single acknowledge cycle
        next_s.waitreq = 1'b1;
        if ((avs_read | avs_write) & s.waitreq)
        begin
            next_s.waitreq = 1'b0;
            if (avs_read)
            begin
                case (avs_address)
                    DCR_OFS_CTRL: next_s.rdata = {16'h0000, s.rsv_pat, 7'h00, s.zero_upper};
                    DCR_OFS_STATUS: next_s.rdata = {11'h000, rl_now, s.cwl_code, s.al_code, s.cl_code, s.bl_mode,
                        s.dll_off, pair_ok, s.ro_loc, s.ro_en, s.pending | s.bursting};
                    DCR_OFS_COUNT: next_s.rdata = {16'h0000, s.rd_count};
                    default: next_s.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= DCR_STATE_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign dq_out = s.dq;
    assign dq_oe = s.dq_oe;
    assign dqs_out = s.dqs;
    assign dqs_n_out = s.dqs_n;
    assign dqs_oe = s.dqs_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [4:0] h_rises;
    logic [4:0] h_rl;
    logic h_mrs_drive;

    assign h_mrs_drive = rise & is_mrs & (s.pin_p.ba[1:0] == DCR_MR_DRIVE);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            h_rises <= 5'h00;
            h_rl <= 5'h00;
        end
        else if (rd_acc)
        begin
            h_rises <= 5'h00;
            h_rl <= rl_now;
        end
        else if (rise && h_rises != 5'h1F)
        begin
            h_rises <= h_rises + 5'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_lanes_mirror;
        s.dq_oe |-> s.dq[7:0] == s.dq[15:8];
    endproperty
    a_lanes_mirror: assert property (p_lanes_mirror) else $error("byte lanes differ during readout");

    property p_upper_bits;
        s.dq_oe |-> s.dq[7:1] == (s.zero_upper ? 7'h00 : {7{s.dq[0]}});
    endproperty
    a_upper_bits: assert property (p_upper_bits) else $error("bits 7..1 neither copy nor zero");

    property p_burst_start;
        $rose(s.dq_oe) |-> s.beat_idx[1:0] == 2'b00 && (s.chop || s.beat_idx[2] == 1'b0);
    endproperty
    a_burst_start: assert property (p_burst_start) else $error("burst starts at wrong beat");

    property p_burst_end;
        $fell(s.dq_oe) |-> $past(s.beat_idx) == ($past(s.chop) ? s.start_idx + 3'h3 : 3'h7);
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("burst ends at wrong beat");

    property p_beat_order;
        s.dq_oe && $past(s.dq_oe) && $changed(s.dqs) |-> s.beat_idx == $past(s.beat_idx) + 3'h1;
    endproperty
    a_beat_order: assert property (p_beat_order) else $error("beats out of order");

    property p_cal_pattern;
        s.dq_oe && s.ro_loc == DCR_LOC_CAL |-> s.dq[0] == s.beat_idx[0];
    endproperty
    a_cal_pattern: assert property (p_cal_pattern) else $error("calibration pattern wrong");

    property p_read_latency;
        $rose(s.dq_oe) |-> h_rises == h_rl;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read latency wrong");

    property p_dll_switch;
        h_mrs_drive |=> s.dll_off == $past(s.pin_p.addr[0]);
    endproperty
    a_dll_switch: assert property (p_dll_switch) else $error("dll-off bit not taken");

    property p_otf_chop;
        rd_acc && s.bl_mode == DCR_BL_OTF |=> s.chop == !$past(s.pin_p.addr[12]);
    endproperty
    a_otf_chop: assert property (p_otf_chop) else $error("on-the-fly chop not honoured");

    property p_strobe_with_data;
        s.dq_oe && $past(s.dq_oe) && $changed(s.dq) |-> $changed(s.dqs);
    endproperty
    a_strobe_with_data: assert property (p_strobe_with_data) else $error("data moved without strobe");

endmodule
